// >>> core/uart_regs_pkg.sv
// package for the serial channel register map and FIFO control
// assumes a byte-wide host bus with three address lines
package uart_regs_pkg;
   localparam logic [2:0] OFS_DATA   = 3'h0;
   localparam logic [2:0] OFS_IEN    = 3'h1;
   localparam logic [2:0] OFS_IDENT  = 3'h2;
   localparam logic [2:0] OFS_LFMT   = 3'h3;
   localparam logic [2:0] OFS_MOUT   = 3'h4;
   localparam logic [2:0] OFS_LSTATE = 3'h5;
   localparam logic [2:0] OFS_MIN    = 3'h6;
   localparam logic [2:0] OFS_SCR    = 3'h7;
   // field positions
   localparam int FC_ON    = 0;
   localparam int FC_RXF   = 1;
   localparam int FC_TXF   = 2;
   localparam int FC_MODE  = 3;
   localparam int LF_DIV   = 7;
   localparam int IE_RX    = 0;
   localparam int IE_TX    = 1;
   localparam int IE_LINE  = 2;
   localparam int IE_MODEM = 3;
   // identity codes
   localparam logic [2:0] ID_NONE  = 3'h0;
   localparam logic [2:0] ID_LINE  = 3'h3;
   localparam logic [2:0] ID_RXAV  = 3'h2;
   localparam logic [2:0] ID_TOUT  = 3'h6;
   localparam logic [2:0] ID_TXE   = 3'h1;
   localparam logic [2:0] ID_MODEM = 3'h0;
   // thresholds
   localparam logic [4:0] TRIG_0 = 5'h01;
   localparam logic [4:0] TRIG_1 = 5'h04;
   localparam logic [4:0] TRIG_2 = 5'h08;
   localparam logic [4:0] TRIG_3 = 5'h0E;
   localparam logic [7:0] RST_LFMT = 8'h00;
   localparam logic [7:0] RST_ZERO = 8'h00;
   localparam int FIFO_DEPTH = 16;
   localparam int CHAR_TIMES = 4;

   typedef struct packed {
      logic       brk;
      logic       frm;
      logic       par;
      logic [7:0] data;
   } rx_entry_t;

   typedef struct packed {
      logic       valid;
      logic [2:0] ident;
   } irq_sel_t;
endpackage

// >>> core/uart_regmap_fifo_control.sv
// register map and FIFO control of one serial channel
// assumes the serial side is synchronous logic on i_clk_sys; modem pins are asynchronous
`default_nettype none

// What this block does
// - line format bit fields; divisor access redirects offsets 0 and 1 to divisor
// - interrupt enable bits 0-3 as sources, bits 7-4 read zero
// - identity bit 0 low while pending, id in 3-1, 5-4 zero, 7-6 fifo on
// - identity bits 7,6,3 and fifo error bit read zero with fifo off
// - line status bits: ready, overrun, parity, framing, break, holding empty, all empty, fifo error
// - modem status: live inputs in 7-4, change flags in 3-0
// - fifo control write-only at offset 2, reads there return identity
// - fifo control bit 0 enables fifos; clearing it empties both
// - any fifo mode change empties both fifos
// - other fifo control bits ignored unless bit 0 set in same write
// - rx flush bit empties rx fifo, leaves shift register alone
// - tx flush bit empties tx fifo, leaves shift register alone
// - mode bit selects ready signalling mode 1 when fifos on
// - bits 7-6 pick rx threshold 1, 4, 8 or 14 bytes
// - fifo control bits 5-4 reserved, no effect
// - data ready sets on character into rx fifo, clears when empty
// - line status interrupt wins over received data available
// - data available when fill reaches threshold, drops below withdraws it
// - time-out after four character times idle with data held, fifo mode only
// - interrupt enable bit 0 also gates the time-out interrupt
module uart_regmap_fifo_control
   import uart_regs_pkg::*;
#(
   parameter int DEPTH = FIFO_DEPTH
)(
   input  wire logic       i_clk_sys,
   input  wire logic       i_arst_n,
   input  wire logic [2:0] i_addr,
   input  wire logic       i_wr,
   input  wire logic       i_rd,
   input  wire logic [7:0] i_wdata,
   output logic      [7:0] o_rdata,
   input  wire logic       i_rx_push,
   input  wire rx_entry_t  i_rx_entry,
   input  wire logic       i_rx_overrun,
   input  wire logic       i_char_tick,
   input  wire logic       i_tx_pop,
   input  wire logic       i_tx_shift_empty,
   output logic      [7:0] o_tx_byte,
   output logic            o_tx_valid,
   input  wire logic       i_cts,
   input  wire logic       i_dsr,
   input  wire logic       i_ring,
   input  wire logic       i_dcd,
   output logic      [7:0] o_line_format,
   output logic      [7:0] o_modem_outputs,
   output logic     [15:0] o_divisor,
   output logic            o_rx_request_out,
   output logic            o_tx_request_out,
   output logic            o_irq
);
   localparam int AW = $clog2(DEPTH);

   // register state
   logic [7:0]  ien_r, ien_nxt, lfmt_r, lfmt_nxt, mout_r, mout_nxt, scr_r, scr_nxt;
   logic [15:0] div_r, div_nxt;
   logic        fifo_on_r, fifo_on_nxt, mode_r, mode_nxt;
   logic [1:0]  trig_r, trig_nxt;
   logic        oe_r, oe_nxt, line_err_r, line_err_nxt;
   logic [3:0]  mdelta_r, mdelta_nxt;
   logic [3:0]  msync1_r, msync2_r, mprev_r;
   logic [2:0]  tocnt_r, tocnt_nxt;
   logic        tout_r, tout_nxt;
   // fifo state
   rx_entry_t   rx_mem [DEPTH];
   logic [7:0]  tx_mem [DEPTH];
   logic [AW-1:0] rx_wp_r, rx_rp_r, tx_wp_r, tx_rp_r;
   logic [AW-1:0] rx_wp_nxt, rx_rp_nxt, tx_wp_nxt, tx_rp_nxt;
   logic [AW:0]   rx_cnt_r, tx_cnt_r, rx_cnt_nxt, tx_cnt_nxt;

   logic wr_data, rd_data, wr_fctl, rd_lstate, rd_min, rx_flush, tx_flush;
   logic rx_do_push, rx_do_pop, tx_do_push, tx_do_pop;
   logic [4:0] trig_level;
   logic [3:0] mnow;
   logic rx_avail, tx_empty_flag, fifo_err;
   irq_sel_t isel;
   logic [7:0] lstate;

   // access decode
   always_comb
   begin
      wr_data   = i_wr && i_addr == OFS_DATA && !lfmt_r[LF_DIV];
      rd_data   = i_rd && i_addr == OFS_DATA && !lfmt_r[LF_DIV];
      wr_fctl   = i_wr && i_addr == OFS_IDENT;
      rd_lstate = i_rd && i_addr == OFS_LSTATE;
      rd_min    = i_rd && i_addr == OFS_MIN;
      // a mode change or clearing bit 0 empties both fifos
      rx_flush  = wr_fctl && ((i_wdata[FC_ON] != fifo_on_r) ||
                  (i_wdata[FC_ON] && i_wdata[FC_RXF]));
      tx_flush  = wr_fctl && ((i_wdata[FC_ON] != fifo_on_r) ||
                  (i_wdata[FC_ON] && i_wdata[FC_TXF]));
   end

   // host-side control registers
   always_comb
   begin
      ien_nxt     = ien_r;
      lfmt_nxt    = lfmt_r;
      mout_nxt    = mout_r;
      scr_nxt     = scr_r;
      div_nxt     = div_r;
      fifo_on_nxt = fifo_on_r;
      mode_nxt    = mode_r;
      trig_nxt    = trig_r;
      if (i_wr)
      begin
         unique case (i_addr)
            OFS_DATA:
            begin
               if (lfmt_r[LF_DIV])
                  div_nxt[7:0] = i_wdata;
            end
            OFS_IEN:
            begin
               if (lfmt_r[LF_DIV])
                  div_nxt[15:8] = i_wdata;
               else
                  ien_nxt = {4'h0, i_wdata[3:0]};
            end
            OFS_IDENT:
            begin
               fifo_on_nxt = i_wdata[FC_ON];
               // bits 5-4 are never stored
               if (i_wdata[FC_ON])
               begin
                  mode_nxt = i_wdata[FC_MODE];
                  trig_nxt = i_wdata[7:6];
               end
            end
            OFS_LFMT:   lfmt_nxt = i_wdata;
            OFS_MOUT:   mout_nxt = {3'h0, i_wdata[4:0]};
            OFS_SCR:    scr_nxt  = i_wdata;
            default:    ;
         endcase
      end
   end

   always_ff @(posedge i_clk_sys or negedge i_arst_n)
   begin
      if (!i_arst_n)
      begin
         ien_r     <= RST_ZERO;
         lfmt_r    <= RST_LFMT;
         mout_r    <= RST_ZERO;
         scr_r     <= RST_ZERO;
         div_r     <= 16'h0000;
         fifo_on_r <= 1'b0;
         mode_r    <= 1'b0;
         trig_r    <= 2'h0;
      end
      else
      begin
         ien_r     <= ien_nxt;
         lfmt_r    <= lfmt_nxt;
         mout_r    <= mout_nxt;
         scr_r     <= scr_nxt;
         div_r     <= div_nxt;
         fifo_on_r <= fifo_on_nxt;
         mode_r    <= mode_nxt;
         trig_r    <= trig_nxt;
      end
   end

   // fifo pointers; without fifo mode only one entry is used
   always_comb
   begin
      rx_do_push = i_rx_push && (rx_cnt_r < (fifo_on_r ? (AW+1)'(DEPTH) : (AW+1)'(1)));
      rx_do_pop  = rd_data && rx_cnt_r != '0;
      tx_do_push = wr_data && (tx_cnt_r < (fifo_on_r ? (AW+1)'(DEPTH) : (AW+1)'(1)));
      tx_do_pop  = i_tx_pop && tx_cnt_r != '0;
      rx_wp_nxt  = rx_wp_r + AW'(rx_do_push);
      rx_rp_nxt  = rx_rp_r + AW'(rx_do_pop);
      rx_cnt_nxt = rx_cnt_r + (AW+1)'(rx_do_push) - (AW+1)'(rx_do_pop);
      tx_wp_nxt  = tx_wp_r + AW'(tx_do_push);
      tx_rp_nxt  = tx_rp_r + AW'(tx_do_pop);
      tx_cnt_nxt = tx_cnt_r + (AW+1)'(tx_do_push) - (AW+1)'(tx_do_pop);
      // flush drops the whole queue; shift registers sit outside
      if (rx_flush)
      begin
         rx_wp_nxt  = '0;
         rx_rp_nxt  = '0;
         rx_cnt_nxt = '0;
      end
      if (tx_flush)
      begin
         tx_wp_nxt  = '0;
         tx_rp_nxt  = '0;
         tx_cnt_nxt = '0;
      end
   end

   always_ff @(posedge i_clk_sys or negedge i_arst_n)
   begin
      if (!i_arst_n)
      begin
         rx_wp_r  <= '0;
         rx_rp_r  <= '0;
         rx_cnt_r <= '0;
         tx_wp_r  <= '0;
         tx_rp_r  <= '0;
         tx_cnt_r <= '0;
      end
      else
      begin
         rx_wp_r  <= rx_wp_nxt;
         rx_rp_r  <= rx_rp_nxt;
         rx_cnt_r <= rx_cnt_nxt;
         tx_wp_r  <= tx_wp_nxt;
         tx_rp_r  <= tx_rp_nxt;
         tx_cnt_r <= tx_cnt_nxt;
      end
   end

   // storage needs no reset; count guards every read
   always_ff @(posedge i_clk_sys)
   begin
      if (rx_do_push)
         rx_mem[rx_wp_r] <= i_rx_entry;
      if (tx_do_push)
         tx_mem[tx_wp_r] <= i_wdata;
   end

   // modem pins through two flops before any use
   always_ff @(posedge i_clk_sys or negedge i_arst_n)
   begin
      if (!i_arst_n)
      begin
         msync1_r <= 4'h0;
         msync2_r <= 4'h0;
         mprev_r  <= 4'h0;
      end
      else
      begin
         msync1_r <= {i_dcd, i_ring, i_dsr, i_cts};
         msync2_r <= msync1_r;
         mprev_r  <= msync2_r;
      end
   end
   assign mnow = msync2_r;

   // sticky status; a new event beats the clearing read
   always_comb
   begin
      oe_nxt       = oe_r;
      line_err_nxt = line_err_r;
      mdelta_nxt   = mdelta_r;
      if (rd_lstate)
      begin
         oe_nxt       = 1'b0;
         line_err_nxt = 1'b0;
      end
      if (rd_min)
         mdelta_nxt = 4'h0;
      if (i_rx_overrun)
         oe_nxt = 1'b1;
      if (rx_do_push && (i_rx_entry.brk || i_rx_entry.frm || i_rx_entry.par))
         line_err_nxt = 1'b1;
      mdelta_nxt[3] = mdelta_nxt[3] | (mnow[3] ^ mprev_r[3]);
      mdelta_nxt[2] = mdelta_nxt[2] | (mprev_r[2] & ~mnow[2]);
      mdelta_nxt[1] = mdelta_nxt[1] | (mnow[1] ^ mprev_r[1]);
      mdelta_nxt[0] = mdelta_nxt[0] | (mnow[0] ^ mprev_r[0]);
   end

   // time-out counter in character ticks, restarted by traffic
   always_comb
   begin
      tocnt_nxt = tocnt_r;
      tout_nxt  = tout_r;
      if (!fifo_on_r || rx_cnt_r == '0 || rx_do_push || rx_do_pop)
      begin
         tocnt_nxt = 3'h0;
         tout_nxt  = 1'b0;
      end
      else if (i_char_tick && !tout_r)
      begin
         tocnt_nxt = tocnt_r + 3'h1;
         if (tocnt_nxt == 3'(CHAR_TIMES))
            tout_nxt = 1'b1;
      end
   end

   always_ff @(posedge i_clk_sys or negedge i_arst_n)
   begin
      if (!i_arst_n)
      begin
         oe_r       <= 1'b0;
         line_err_r <= 1'b0;
         mdelta_r   <= 4'h0;
         tocnt_r    <= 3'h0;
         tout_r     <= 1'b0;
      end
      else
      begin
         oe_r       <= oe_nxt;
         line_err_r <= line_err_nxt;
         mdelta_r   <= mdelta_nxt;
         tocnt_r    <= tocnt_nxt;
         tout_r     <= tout_nxt;
      end
   end

   // fifo error: any flagged entry still queued
   always_comb
   begin
      fifo_err = 1'b0;
      for (int k = 0; k < DEPTH; k++)
         if (AW'(k) - rx_rp_r < rx_cnt_r[AW-1:0] || rx_cnt_r[AW])
            fifo_err = fifo_err | rx_mem[k].brk | rx_mem[k].frm | rx_mem[k].par;
   end

   // line status and thresholds
   always_comb
   begin
      unique case (trig_r)
         2'h0: trig_level = TRIG_0;
         2'h1: trig_level = TRIG_1;
         2'h2: trig_level = TRIG_2;
         2'h3: trig_level = TRIG_3;
      endcase
      tx_empty_flag = tx_cnt_r == '0;
      lstate[0] = rx_cnt_r != '0;
      lstate[1] = oe_r;
      lstate[2] = rx_cnt_r != '0 && rx_mem[rx_rp_r].par;
      lstate[3] = rx_cnt_r != '0 && rx_mem[rx_rp_r].frm;
      lstate[4] = rx_cnt_r != '0 && rx_mem[rx_rp_r].brk;
      lstate[5] = tx_empty_flag;
      lstate[6] = tx_empty_flag && i_tx_shift_empty;
      lstate[7] = fifo_on_r && fifo_err;
      rx_avail  = fifo_on_r ? ({{(4-AW){1'b0}}, rx_cnt_r} >= trig_level)
                            : (rx_cnt_r != '0);
   end

   // priority encoder, line status first
   always_comb
   begin
      isel = '{valid: 1'b0, ident: ID_NONE};
      if (ien_r[IE_LINE] && (oe_r || line_err_r))
         isel = '{valid: 1'b1, ident: ID_LINE};
      else if (ien_r[IE_RX] && rx_avail)
         isel = '{valid: 1'b1, ident: ID_RXAV};
      else if (ien_r[IE_RX] && tout_r)
         isel = '{valid: 1'b1, ident: ID_TOUT};
      else if (ien_r[IE_TX] && tx_empty_flag)
         isel = '{valid: 1'b1, ident: ID_TXE};
      else if (ien_r[IE_MODEM] && mdelta_r != 4'h0)
         isel = '{valid: 1'b1, ident: ID_MODEM};
   end

   // read mux, registered so data outputs come from flops
   always_ff @(posedge i_clk_sys or negedge i_arst_n)
   begin
      if (!i_arst_n)
         o_rdata <= 8'h00;
      else if (i_rd)
      begin
         unique case (i_addr)
            OFS_DATA:   o_rdata <= lfmt_r[LF_DIV] ? div_r[7:0] :
                                   (rx_cnt_r != '0 ? rx_mem[rx_rp_r].data : 8'h00);
            OFS_IEN:    o_rdata <= lfmt_r[LF_DIV] ? div_r[15:8] : ien_r;
            OFS_IDENT:  o_rdata <= {fifo_on_r, fifo_on_r, 2'b00,
                                    isel.ident[2] & fifo_on_r,
                                    isel.ident[1:0], ~isel.valid};
            OFS_LFMT:   o_rdata <= lfmt_r;
            OFS_MOUT:   o_rdata <= mout_r;
            OFS_LSTATE: o_rdata <= lstate;
            OFS_MIN:    o_rdata <= {mnow, mdelta_r};
            OFS_SCR:    o_rdata <= scr_r;
            default:    o_rdata <= 8'h00;
         endcase
      end
   end

   // ready outputs: mode 1 only with fifos on
   always_comb
   begin
      if (fifo_on_r && mode_r)
      begin
         o_rx_request_out = rx_avail || tout_r;
         o_tx_request_out = tx_cnt_r != (AW+1)'(DEPTH);
      end
      else
      begin
         o_rx_request_out = rx_cnt_r != '0;
         o_tx_request_out = tx_empty_flag && i_tx_shift_empty;
      end
   end

   assign o_tx_byte       = tx_mem[tx_rp_r];
   assign o_tx_valid      = tx_cnt_r != '0;
   assign o_line_format   = lfmt_r;
   assign o_modem_outputs = mout_r;
   assign o_divisor       = div_r;
   assign o_irq           = isel.valid && mout_r[3];
endmodule

`default_nettype wire

// >>> dv/uart_regmap_fifo_control_monitor.sv
// checker for the serial channel register map, sees only top ports
// assumes one clock domain and the registered read path of the block
`default_nettype none
module uart_regmap_fifo_control_monitor
   import uart_regs_pkg::*;
(
   input  wire logic        i_clk_sys,
   input  wire logic        i_arst_n,
   input  wire logic [2:0]  i_addr,
   input  wire logic        i_wr,
   input  wire logic        i_rd,
   input  wire logic [7:0]  i_wdata,
   input  wire logic [7:0]  o_rdata,
   input  wire logic        o_tx_valid,
   input  wire logic [7:0]  o_line_format,
   input  wire logic [15:0] o_divisor,
   input  wire logic        o_irq
);
   timeunit 1ns;
   timeprecision 1ns;

   default clocking cb @(posedge i_clk_sys);
   endclocking
   default disable iff (!i_arst_n);

   // divisor path only while access select is set
   chk_div_low: assert property (i_wr && i_addr == OFS_DATA && o_line_format[LF_DIV]
      |=> o_divisor[7:0] == $past(i_wdata)) else $error("divisor low not written");
   chk_div_high: assert property (i_wr && i_addr == OFS_IEN && o_line_format[LF_DIV]
      |=> o_divisor[15:8] == $past(i_wdata)) else $error("divisor high not written");
   chk_div_kept: assert property (i_wr && i_addr == OFS_DATA && !o_line_format[LF_DIV]
      |=> $stable(o_divisor)) else $error("divisor changed by data write");
   chk_lfmt_write: assert property (i_wr && i_addr == OFS_LFMT
      |=> o_line_format == $past(i_wdata)) else $error("line format not written");
   chk_lfmt_read: assert property (i_rd && i_addr == OFS_LFMT
      |=> o_rdata == $past(o_line_format)) else $error("line format read wrong");
   // fixed zero fields of enable and identity
   chk_ien_upper: assert property (i_rd && i_addr == OFS_IEN && !o_line_format[LF_DIV]
      |=> o_rdata[7:4] == 4'h0) else $error("enable upper bits not zero");
   chk_ident_fixed: assert property (i_rd && i_addr == OFS_IDENT
      |=> o_rdata[5:4] == 2'h0 && o_rdata[7] == o_rdata[6]) else $error("identity fixed bits");
   chk_ident_off: assert property (i_rd && i_addr == OFS_IDENT
      |=> !o_rdata[3] || o_rdata[7]) else $error("identity bit 3 with fifo off");
   chk_tx_flush: assert property (i_wr && i_addr == OFS_IDENT && i_wdata[FC_ON]
      && i_wdata[FC_TXF] |=> !o_tx_valid) else $error("tx fifo not flushed");

   cover property (i_wr && i_addr == OFS_IDENT && i_wdata[FC_ON]);
   cover property (o_irq);
   cover property (i_rd && i_addr == OFS_DATA && o_line_format[LF_DIV]);
endmodule

bind uart_regmap_fifo_control uart_regmap_fifo_control_monitor mon (
   .i_clk_sys(i_clk_sys), .i_arst_n(i_arst_n), .i_addr(i_addr), .i_wr(i_wr),
   .i_rd(i_rd), .i_wdata(i_wdata), .o_rdata(o_rdata), .o_tx_valid(o_tx_valid),
   .o_line_format(o_line_format), .o_divisor(o_divisor), .o_irq(o_irq));
`default_nettype wire

// >>> dv/uart_host_model.sv
// host processor model on the byte-wide register bus
// assumes registered read data one cycle after the read strobe edge
`default_nettype none
module uart_host_model (
   input  wire logic       i_clk_sys,
   input  wire logic [7:0] i_rdata,
   output logic      [2:0] o_addr,
   output logic            o_wr,
   output logic            o_rd,
   output logic      [7:0] o_wdata
);
   timeunit 1ns;
   timeprecision 1ns;

   // idle bus at time zero
   initial
   begin
      o_addr = 3'h0;
      o_wr = 1'b0;
      o_rd = 1'b0;
      o_wdata = 8'h00;
   end

   // strobe held over exactly one sampling edge
   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      @(posedge i_clk_sys);
      o_addr <= a;
      o_wdata <= d;
      o_wr <= 1'b1;
      @(posedge i_clk_sys);
      o_wr <= 1'b0;
      o_wdata <= ~d; // released bus must not look valid
      #1;
   endtask

   task automatic rd(input logic [2:0] a, output logic [7:0] d);
      @(posedge i_clk_sys);
      o_addr <= a;
      o_rd <= 1'b1;
      @(posedge i_clk_sys);
      o_rd <= 1'b0;
      #1;
      d = i_rdata;
   endtask
endmodule
`default_nettype wire

// >>> dv/uart_regmap_fifo_control_tb.sv
// self-checking bench for the serial channel register map and fifos
// assumes the host model drives the bus; serial side driven here
`default_nettype none
module uart_regmap_fifo_control_tb
   import uart_regs_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;

   logic clk = 1'b0, arst_n = 1'b0, wr, rd, push = 1'b0, tick = 1'b0, pop = 1'b0;
   logic cts = 1'b0, dsr = 1'b0, ring = 1'b0, dcd = 1'b0;
   logic ovr = 1'b0, sh_empty = 1'b1;
   logic [2:0] addr;
   logic [7:0] wdata, rdata, txb, lfmt, mout, d, v, lo;
   logic [15:0] div;
   logic [3:0] m;
   rx_entry_t ent = '0;
   logic txv, rxq, txq, irq;
   logic [31:0] seed;
   logic [7:0] q[$];
   logic [4:0] trg [4] = '{TRIG_0, TRIG_1, TRIG_2, TRIG_3};
   int fails = 0, samples_checked = 0;

   always #25 clk = ~clk;

   uart_host_model host (.i_clk_sys(clk), .i_rdata(rdata), .o_addr(addr), .o_wr(wr),
      .o_rd(rd), .o_wdata(wdata));

   // serial side driven straight from here: shifters lie outside this block
   uart_regmap_fifo_control dut (.i_clk_sys(clk), .i_arst_n(arst_n), .i_addr(addr),
      .i_wr(wr), .i_rd(rd), .i_wdata(wdata), .o_rdata(rdata), .i_rx_push(push),
      .i_rx_entry(ent), .i_rx_overrun(ovr), .i_char_tick(tick), .i_tx_pop(pop),
      .i_tx_shift_empty(sh_empty), .o_tx_byte(txb), .o_tx_valid(txv), .i_cts(cts),
      .i_dsr(dsr), .i_ring(ring), .i_dcd(dcd), .o_line_format(lfmt),
      .o_modem_outputs(mout), .o_divisor(div), .o_rx_request_out(rxq),
      .o_tx_request_out(txq), .o_irq(irq));

   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction

   task automatic nxt(output logic [7:0] r);
      seed = lfsr(seed);
      r = seed[7:0];
   endtask

   task automatic chk(input string n, input logic [15:0] seen, input logic [15:0] exp);
      samples_checked++;
      if (seen !== exp)
      begin
         fails++;
         $display("[FAIL] %s expected %h seen %h", n, exp, seen);
      end
   endtask

   task automatic rdc(input logic [2:0] a, input logic [7:0] e, input string n);
      host.rd(a, d);
      chk(n, {8'h00, d}, {8'h00, e});
   endtask

   // one-cycle pulses on the serial side
   task automatic rxp(input logic [10:0] e);
      @(posedge clk);
      push <= 1'b1;
      ent <= e;
      @(posedge clk);
      push <= 1'b0;
      #1;
   endtask

   task automatic txpop;
      @(posedge clk);
      pop <= 1'b1;
      @(posedge clk);
      pop <= 1'b0;
      #1;
   endtask

   task automatic end_sim;
      if (fails == 0 && samples_checked > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   // run takes a few hundred cycles, so 1 ms means a hang
   initial
   begin
      #1000000;
      fails++;
      end_sim();
   end

   initial
   begin
      seed = 32'h0001252A;
      repeat (2) @(posedge clk);
      arst_n <= 1'b1;
      // reset state
      rdc(OFS_LFMT, 8'h00, "lfmt");
      rdc(OFS_IEN, 8'h00, "ien");
      rdc(OFS_IDENT, 8'h01, "ident");
      rdc(OFS_LSTATE, 8'h60, "lstate");
      // plain registers with random data
      nxt(v);
      host.wr(OFS_SCR, v);
      rdc(OFS_SCR, v, "scratch");
      host.wr(OFS_IEN, v);
      rdc(OFS_IEN, v & 8'h0F, "ien");
      host.wr(OFS_LFMT, v & 8'h7F);
      rdc(OFS_LFMT, v & 8'h7F, "lfmt");
      // divisor behind access select
      host.wr(OFS_LFMT, 8'h80);
      nxt(lo);
      nxt(v);
      host.wr(OFS_DATA, lo);
      host.wr(OFS_IEN, v);
      chk("divisor", div, {v, lo});
      rdc(OFS_DATA, lo, "div_lo");
      rdc(OFS_IEN, v, "div_hi");
      host.wr(OFS_LFMT, 8'h00);
      // thresholds; reserved bits random; rx flush each time
      host.wr(OFS_MOUT, 8'h08);
      chk("mout", {8'h00, mout}, 16'h0008);
      host.wr(OFS_IEN, 8'h05);
      for (int k = 0; k < 4; k++)
      begin
         nxt(v);
         host.wr(OFS_IDENT, {k[1:0], v[5:4], 4'h3});
         q.delete();
         for (int n = 0; n < trg[k]; n++)
         begin
            nxt(v);
            q.push_back(v);
            rxp({3'h0, v});
            chk("irq", {15'h0, irq}, {15'h0, n == trg[k] - 1});
            chk("rx_req", {15'h0, rxq}, 16'h1);
         end
         rdc(OFS_IDENT, 8'hC4, "ident");
         rdc(OFS_LSTATE, 8'h61, "lstate");
         rdc(OFS_DATA, q[0], "rx_data");
         chk("irq", {15'h0, irq}, 16'h0);
         host.wr(OFS_IDENT, {k[1:0], 6'h03});
         rdc(OFS_LSTATE, 8'h60, "lstate");
      end
      // line status ahead of data available
      host.wr(OFS_IDENT, 8'h03);
      nxt(v);
      rxp({3'h1, v});
      rdc(OFS_IDENT, 8'hC6, "ident");
      rdc(OFS_LSTATE, 8'hE5, "lstate");
      rdc(OFS_IDENT, 8'hC4, "ident");
      rdc(OFS_DATA, v, "rx_data");
      rdc(OFS_LSTATE, 8'h60, "lstate");
      // overrun alone raises line status; a busy shifter drops all-empty
      @(posedge clk);
      ovr <= 1'b1;
      sh_empty <= 1'b0;
      @(posedge clk);
      ovr <= 1'b0;
      rdc(OFS_IDENT, 8'hC6, "ident");
      rdc(OFS_LSTATE, 8'h22, "lstate");
      @(posedge clk);
      sh_empty <= 1'b1;
      rdc(OFS_LSTATE, 8'h60, "lstate");
      // time-out below threshold, then gated by enable bit 0
      host.wr(OFS_IDENT, 8'hCB);
      rxp({3'h0, v});
      chk("rx_req", {15'h0, rxq}, 16'h0);
      repeat (CHAR_TIMES)
      begin
         @(posedge clk);
         tick <= 1'b1;
         @(posedge clk);
         tick <= 1'b0;
      end
      rdc(OFS_IDENT, 8'hCC, "ident");
      chk("rx_req", {15'h0, rxq}, 16'h1);
      host.wr(OFS_IEN, 8'h04);
      #1;
      chk("irq", {15'h0, irq}, 16'h0);
      rdc(OFS_IDENT, 8'hC1, "ident");
      rdc(OFS_DATA, v, "rx_data");
      // mode 1, fill tx fifo past full, drain in order
      host.wr(OFS_IDENT, 8'h0F);
      chk("tx_req", {15'h0, txq}, 16'h1);
      q.delete();
      for (int n = 0; n < 17; n++)
      begin
         nxt(v);
         q.push_back(v);
         host.wr(OFS_DATA, v);
      end
      chk("tx_req", {15'h0, txq}, 16'h0);
      for (int n = 0; n < 16; n++)
      begin
         chk("tx_byte", {8'h00, txb}, {8'h00, q[n]});
         txpop();
      end
      chk("tx_valid", {15'h0, txv}, 16'h0);
      host.wr(OFS_DATA, v);
      host.wr(OFS_IDENT, 8'h0D);
      chk("tx_valid", {15'h0, txv}, 16'h0);
      // leaving and entering fifo mode empties fifos
      host.wr(OFS_DATA, v);
      host.wr(OFS_IDENT, 8'h00);
      chk("tx_valid", {15'h0, txv}, 16'h0);
      rdc(OFS_IDENT, 8'h01, "ident");
      host.wr(OFS_DATA, v);
      host.wr(OFS_IDENT, 8'h04);
      chk("tx_valid", {15'h0, txv}, 16'h1);
      host.wr(OFS_IDENT, 8'h01);
      chk("tx_valid", {15'h0, txv}, 16'h0);
      // modem inputs rise from idle: live bits and change flags
      nxt(v);
      m = v[3:0] | 4'h5;
      @(posedge clk);
      {dcd, ring, dsr, cts} <= m;
      repeat (4) @(posedge clk);
      rdc(OFS_MIN, {m, m[3], 1'b0, m[1], m[0]}, "modem");
      rdc(OFS_MIN, {m, 4'h0}, "modem");
      // inputs fall back: ring now flags its trailing edge
      @(posedge clk);
      {dcd, ring, dsr, cts} <= 4'h0;
      repeat (4) @(posedge clk);
      rdc(OFS_MIN, {4'h0, m}, "modem");
      // mid-run reset clears registers and turns the fifos off
      host.wr(OFS_SCR, 8'hA5);
      @(posedge clk);
      arst_n <= 1'b0;
      repeat (2) @(posedge clk);
      arst_n <= 1'b1;
      rdc(OFS_SCR, 8'h00, "scratch");
      rdc(OFS_IDENT, 8'h01, "ident");
      end_sim();
   end
endmodule
`default_nettype wire
